// file: rtl/vpe_map.svh
// offsets, field positions, reset values and timing counts of the voltage element
// assumes a plain register port with byte addresses and 32-bit read data
`ifndef VPE_MAP_SVH
`define VPE_MAP_SVH

`define VPE_OFF_CFG      8'h00
`define VPE_OFF_THR      8'h04
`define VPE_OFF_DROP     8'h08
`define VPE_OFF_TDLY     8'h0C
`define VPE_OFF_IMIN     8'h10
`define VPE_OFF_IREL     8'h14
`define VPE_OFF_VTSEC    8'h18
`define VPE_OFF_STAT     8'h1C

`define VPE_CFG_FUNC     0
`define VPE_CFG_OV       1
`define VPE_CFG_METH_LO  2
`define VPE_CFG_METH_HI  3
`define VPE_CFG_VTPP     4
`define VPE_CFG_MODEPP   5
`define VPE_CFG_VOTE_LO  6
`define VPE_CFG_VOTE_HI  7
`define VPE_CFG_IMINEN   8
`define VPE_CFG_HVRT     9
`define VPE_CFG_W        10

`define VPE_RST_CFG      10'h040
`define VPE_RST_THR      16'h0400
`define VPE_RST_DROP     16'h03E1
`define VPE_RST_TDLY     16'h0064
`define VPE_RST_IMIN     16'h0000
`define VPE_RST_IREL     16'h0064
`define VPE_RST_VTSEC    16'h0064

// 1/sqrt(3) in steps of 1/1024, and the 10 fraction bits of that scale
`define VPE_INV_SQRT3    16'h024F
`define VPE_FRAC_BITS    10

// delay counters advance once per millisecond
`define VPE_CLK_NS       4
`define VPE_TICK_NS      1000000
`define VPE_TICK_CYC     (`VPE_TICK_NS / `VPE_CLK_NS)

`endif

// file: rtl/vpe_pkg.sv
// types of the voltage protection element
// assumes vpe_map.svh for all numeric constants
package vpe_pkg;

    typedef enum logic [1:0] {
        METH_FUND,
        METH_RMS,
        METH_AVG,
        METH_SPARE
    } vpe_method_t;

    typedef enum logic [1:0] {
        BLK_RUN,
        BLK_DEAD,
        BLK_WAIT
    } vpe_blk_t;

    typedef struct packed {
        logic [9:0]  cfg;
        logic [15:0] thr;
        logic [15:0] drop;
        logic [15:0] tdly;
        logic [15:0] imin;
        logic [15:0] irel;
        logic [15:0] vtsec;
        logic [23:0] tickCnt;
        logic        tick;
        logic [15:0] delCnt;
        logic [15:0] relCnt;
        vpe_blk_t    blk;
        logic [2:0]  phFlag;
        logic [2:0]  pickFlag;
        logic [2:0]  tripFlag;
        logic        elemPick;
        logic        elemTrip;
        logic [31:0] rdata;
    } vpe_state_t;

endpackage

// file: rtl/vpe_element.sv
// voltage protection element: under/overvoltage decision with vote, hysteresis,
// trip delay, minimum-current release and ride-through variant
// assumes measurements synchronous to mclk; line voltages come precomputed
//
// Operation
// - fundamental or true RMS per method setting
// - method may choose sliding average instead
// - ground connection, ground mode: rating over root3
// - ground connection, line mode: rating itself
// - line connection forces line mode, rating
// - current release only in undervoltage, when enabled
// - check disabled: currents have no influence
// - all currents below threshold block element
// - current returns: stay blocked for release delay
// - pickup vote one, two or three phases
// - dropout ratio gives reset hysteresis
// - trip delay runs from threshold crossing
// - overvoltage resets at dropout ratio, e.g. 97%
// - undervoltage resets at dropout ratio, e.g. 103%
// - ground connection, ground mode: flags follow phase voltages
// - line connection: flags follow 12, 23, 31
// - ride-through exists only when planned overvoltage
// - ride-through runs only with function active
// - ride-through picks up on overvoltage only
`timescale 1ns/1ps
`include "vpe_map.svh"

module vpe_element #(
    parameter int unsigned TICK_CYCLES = `VPE_TICK_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [7:0]        regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [31:0]       regRdata,
    input  wire logic [2:0][15:0]  phaseFund,
    input  wire logic [2:0][15:0]  phaseRms,
    input  wire logic [2:0][15:0]  phaseAvg,
    input  wire logic [2:0][15:0]  lineFund,
    input  wire logic [2:0][15:0]  lineRms,
    input  wire logic [2:0][15:0]  lineAvg,
    input  wire logic [2:0][15:0]  phaseCurrent,
    output logic      [2:0]        phasePickupFlag,
    output logic      [2:0]        phaseTripFlag,
    output logic                   elementPickup,
    output logic                   elementTrip
);

    // whole state in one register; s_d is its next value
    vpe_pkg::vpe_state_t s_q;
    vpe_pkg::vpe_state_t s_d;

    // decoded settings
    logic                  funcOn;
    logic                  ovMode;
    logic                  hvrt;
    logic                  active;
    logic                  linePath;
    logic                  groundNom;
    logic [1:0]            vote;
    vpe_pkg::vpe_method_t  meth;
    logic [15:0]           vnRef;
    logic [31:0]           vnProd;
    logic [31:0]           pickProd;
    logic [31:0]           dropProd;
    logic [15:0]           pickLevel;
    logic [15:0]           dropLevel;
    logic [2:0][15:0]      meas;
    logic [2:0]            beyondPick;
    logic [2:0]            withinDrop;
    logic [2:0]            curLow;
    logic                  allLow;
    logic                  checkOn;
    logic [1:0]            votes;

    assign funcOn   = s_q.cfg[`VPE_CFG_FUNC];
    assign hvrt     = s_q.cfg[`VPE_CFG_HVRT];
    // ride-through variant is overvoltage only; otherwise inert
    assign active   = funcOn & (~hvrt | s_q.cfg[`VPE_CFG_OV]);
    assign ovMode   = s_q.cfg[`VPE_CFG_OV];
    assign vote     = s_q.cfg[`VPE_CFG_VOTE_HI:`VPE_CFG_VOTE_LO];
    // sliding average is not offered by the ride-through variant
    // code 3 is spare and falls back to the fundamental
    always_comb begin
        case (s_q.cfg[`VPE_CFG_METH_HI:`VPE_CFG_METH_LO])
            2'h1: begin
                meth = vpe_pkg::METH_RMS;
            end
            2'h2: begin
                meth = hvrt ? vpe_pkg::METH_FUND : vpe_pkg::METH_AVG;
            end
            default: begin
                meth = vpe_pkg::METH_FUND;
            end
        endcase
    end
    // with a line connection the phase ports already carry line voltages
    assign linePath  = ~s_q.cfg[`VPE_CFG_VTPP] & s_q.cfg[`VPE_CFG_MODEPP];
    assign groundNom = ~s_q.cfg[`VPE_CFG_VTPP] & ~s_q.cfg[`VPE_CFG_MODEPP];
    assign vnProd    = s_q.vtsec * `VPE_INV_SQRT3;
    always_comb begin
        if (groundNom) begin
            vnRef = vnProd[25:10];
        end else if (linePath) begin
            vnRef = s_q.vtsec;
        end else begin
            vnRef = s_q.vtsec;
        end
    end

    // thresholds are per-unit of the nominal reference, 10 fraction bits
    // saturate so an oversized setting cannot wrap to a low level
    assign pickProd  = s_q.thr * vnRef;
    always_comb begin
        if (pickProd[31:26] != 6'h00) begin
            pickLevel = 16'hFFFF;
        end else begin
            pickLevel = pickProd[25:10];
        end
    end
    assign dropProd  = pickLevel * s_q.drop;
    always_comb begin
        if (dropProd[31:26] != 6'h00) begin
            dropLevel = 16'hFFFF;
        end else begin
            dropLevel = dropProd[25:10];
        end
    end

    always_comb begin
        case (meth)
            vpe_pkg::METH_RMS: begin
                meas = linePath ? lineRms : phaseRms;
            end
            vpe_pkg::METH_AVG: begin
                meas = linePath ? lineAvg : phaseAvg;
            end
            default: begin
                meas = linePath ? lineFund : phaseFund;
            end
        endcase
    end

    // per-phase comparisons; flag n follows input channel n in either connection
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_phase
            assign beyondPick[ph] = ovMode ? (meas[ph] > pickLevel)
                                           : (meas[ph] < pickLevel);
            assign withinDrop[ph] = ovMode ? (meas[ph] < dropLevel)
                                           : (meas[ph] > dropLevel);
            assign curLow[ph]     = phaseCurrent[ph] < s_q.imin;
        end
    endgenerate

    assign allLow  = &curLow;
    // currents say nothing useful to an overvoltage decision
    assign checkOn = s_q.cfg[`VPE_CFG_IMINEN] & ~ovMode & ~hvrt;
    assign votes   = 2'(s_q.phFlag[0]) + 2'(s_q.phFlag[1]) + 2'(s_q.phFlag[2]);

    always_comb begin
        s_d = s_q;

        // millisecond enable
        // one shared divider keeps every delay on the same grid
        s_d.tick = 1'b0;
        if (s_q.tickCnt >= 24'(TICK_CYCLES - 1)) begin
            s_d.tickCnt = 24'h000000;
            s_d.tick    = 1'b1;
        end else begin
            s_d.tickCnt = s_q.tickCnt + 24'h000001;
        end

        // register writes
        if (regWr) begin
            case (regAddr)
                `VPE_OFF_CFG: begin
                    s_d.cfg = regWdata[`VPE_CFG_W-1:0];
                end
                `VPE_OFF_THR: begin
                    s_d.thr = regWdata[15:0];
                end
                `VPE_OFF_DROP: begin
                    s_d.drop = regWdata[15:0];
                end
                `VPE_OFF_TDLY: begin
                    s_d.tdly = regWdata[15:0];
                end
                `VPE_OFF_IMIN: begin
                    s_d.imin = regWdata[15:0];
                end
                `VPE_OFF_IREL: begin
                    s_d.irel = regWdata[15:0];
                end
                `VPE_OFF_VTSEC: begin
                    s_d.vtsec = regWdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // register reads, answer stands the next cycle only
        s_d.rdata = 32'h00000000;
        if (regRd) begin
            case (regAddr)
                `VPE_OFF_CFG: begin
                    s_d.rdata = {22'h000000, s_q.cfg};
                end
                `VPE_OFF_THR: begin
                    s_d.rdata = {16'h0000, s_q.thr};
                end
                `VPE_OFF_DROP: begin
                    s_d.rdata = {16'h0000, s_q.drop};
                end
                `VPE_OFF_TDLY: begin
                    s_d.rdata = {16'h0000, s_q.tdly};
                end
                `VPE_OFF_IMIN: begin
                    s_d.rdata = {16'h0000, s_q.imin};
                end
                `VPE_OFF_IREL: begin
                    s_d.rdata = {16'h0000, s_q.irel};
                end
                `VPE_OFF_VTSEC: begin
                    s_d.rdata = {16'h0000, s_q.vtsec};
                end
                `VPE_OFF_STAT: begin
                    s_d.rdata = {21'h000000,
                                 s_q.blk,
                                 active,
                                 s_q.elemTrip,
                                 s_q.elemPick,
                                 s_q.tripFlag,
                                 s_q.pickFlag};
                end
                default: begin
                    s_d.rdata = 32'h00000000;
                end
            endcase
        end

        // minimum-current release
        if (!checkOn) begin
            s_d.blk    = vpe_pkg::BLK_RUN;
            s_d.relCnt = 16'h0000;
        end else begin
            case (s_q.blk)
                vpe_pkg::BLK_RUN: begin
                    if (allLow) begin
                        s_d.blk = vpe_pkg::BLK_DEAD;
                    end
                end
                vpe_pkg::BLK_DEAD: begin
                    s_d.relCnt = 16'h0000;
                    if (!allLow) begin
                        s_d.blk = vpe_pkg::BLK_WAIT;
                    end
                end
                vpe_pkg::BLK_WAIT: begin
                    if (allLow) begin
                        s_d.blk    = vpe_pkg::BLK_DEAD;
                        s_d.relCnt = 16'h0000;
                    end else if (s_q.relCnt >= s_q.irel) begin
                        s_d.blk    = vpe_pkg::BLK_RUN;
                        s_d.relCnt = 16'h0000;
                    end else if (s_q.tick) begin
                        s_d.relCnt = s_q.relCnt + 16'h0001;
                    end
                end
                default: begin
                    s_d.blk = vpe_pkg::BLK_DEAD;
                end
            endcase
        end

        // per-phase hysteresis, then vote and trip timing
        // a blocked element holds no flag, so release restarts the delay
        if (!active || s_q.blk != vpe_pkg::BLK_RUN) begin
            s_d.phFlag   = 3'h0;
            s_d.elemPick = 1'b0;
            s_d.elemTrip = 1'b0;
            s_d.delCnt   = 16'h0000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (beyondPick[i]) begin
                    s_d.phFlag[i] = 1'b1;
                end else if (withinDrop[i]) begin
                    s_d.phFlag[i] = 1'b0;
                end
            end
            // a vote of zero is treated as one of three
            s_d.elemPick = (votes != 2'h0) && (votes >= vote);
            if (!s_d.elemPick) begin
                s_d.delCnt   = 16'h0000;
                s_d.elemTrip = 1'b0;
            end else if (s_q.delCnt >= s_q.tdly) begin
                s_d.elemTrip = 1'b1;
            end else if (s_q.tick) begin
                s_d.delCnt = s_q.delCnt + 16'h0001;
            end
        end

        s_d.pickFlag = s_d.elemPick ? s_d.phFlag : 3'h0;
        s_d.tripFlag = s_d.elemTrip ? s_d.phFlag : 3'h0;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q.cfg      <= `VPE_RST_CFG;
            s_q.thr      <= `VPE_RST_THR;
            s_q.drop     <= `VPE_RST_DROP;
            s_q.tdly     <= `VPE_RST_TDLY;
            s_q.imin     <= `VPE_RST_IMIN;
            s_q.irel     <= `VPE_RST_IREL;
            s_q.vtsec    <= `VPE_RST_VTSEC;
            s_q.tickCnt  <= 24'h000000;
            s_q.tick     <= 1'b0;
            s_q.delCnt   <= 16'h0000;
            s_q.relCnt   <= 16'h0000;
            s_q.blk      <= vpe_pkg::BLK_RUN;
            s_q.phFlag   <= 3'h0;
            s_q.pickFlag <= 3'h0;
            s_q.tripFlag <= 3'h0;
            s_q.elemPick <= 1'b0;
            s_q.elemTrip <= 1'b0;
            s_q.rdata    <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    // every output is a register bit
    assign regRdata        = s_q.rdata;
    assign phasePickupFlag = s_q.pickFlag;
    assign phaseTripFlag   = s_q.tripFlag;
    assign elementPickup   = s_q.elemPick;
    assign elementTrip     = s_q.elemTrip;

endmodule // vpe_element

// file: testbench/vpe_meas_model.sv
// measurement front end model: one quantity set carries the levels
// assumes sel and levels are driven by the bench at mclk edges
`timescale 1ns/1ps
module vpe_meas_model (
    input  wire logic [1:0]       sel,
    input  wire logic [2:0][15:0] level,
    input  wire logic [2:0][15:0] amps,
    output logic      [2:0][15:0] phaseFund,
    output logic      [2:0][15:0] phaseRms,
    output logic      [2:0][15:0] phaseAvg,
    output logic      [2:0][15:0] lineFund,
    output logic      [2:0][15:0] lineRms,
    output logic      [2:0][15:0] lineAvg,
    output logic      [2:0][15:0] phaseCurrent
);
    // unselected sets sit at zero so a wrong pick shows at once
    assign phaseFund    = (sel == 2'h0) ? level : '0;
    assign phaseRms     = (sel == 2'h1) ? level : '0;
    assign phaseAvg     = (sel == 2'h2) ? level : '0;
    assign lineFund     = phaseFund;
    assign lineRms      = phaseRms;
    assign lineAvg      = phaseAvg;
    assign phaseCurrent = amps;
endmodule // vpe_meas_model

// file: testbench/vpe_element_monitor.sv
// port checker of the voltage element
// assumes one clock mclk and async reset rst
`timescale 1ns/1ps
module vpe_element_monitor #(
    parameter int unsigned TICK_CYCLES = 250000
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic [2:0]  phasePickupFlag,
    input wire logic [2:0]  phaseTripFlag,
    input wire logic        elementPickup,
    input wire logic        elementTrip
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence thrWrRd;
        regWr && regAddr == 8'h04 ##1 regRd && regAddr == 8'h04;
    endsequence
    AST_THR_READBACK: assert property (thrWrRd |=> regRdata == {16'h0000, $past(regWdata[15:0], 2)})
        else $error("threshold readback wrong");
    AST_RD_IDLE_ZERO: assert property (!$past(regRd) |-> regRdata == 32'h00000000)
        else $error("read data not zero when idle");
    AST_RD_UPPER_ZERO: assert property ($past(regRd) |-> regRdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    AST_TRIP_AFTER_PICK: assert property ($rose(elementTrip) |-> elementPickup)
        else $error("trip without earlier pickup");
    AST_TRIP_NEEDS_PICK: assert property (elementTrip |-> elementPickup || $past(elementPickup))
        else $error("trip held without pickup");
    AST_DROP_CLEARS_TRIP: assert property (!elementPickup [*2] |-> !elementTrip)
        else $error("trip stays after dropout");
    AST_PICK_HAS_FLAG: assert property (elementPickup |-> (phasePickupFlag | $past(phasePickupFlag)) != 3'h0)
        else $error("pickup with no phase flag");
    AST_TFLAG_PFLAG: assert property ((phaseTripFlag & ~(phasePickupFlag | $past(phasePickupFlag))) == 3'h0)
        else $error("phase trip without phase pickup");
    AST_RESET_QUIET: assert property ($fell(rst) |-> !elementPickup && !elementTrip)
        else $error("outputs active after reset");
endmodule // vpe_element_monitor
bind vpe_element vpe_element_monitor #(.TICK_CYCLES(TICK_CYCLES)) uMon (.mclk, .rst, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .phasePickupFlag, .phaseTripFlag, .elementPickup,
    .elementTrip);

// file: testbench/vpe_element_test.sv
// self-checking bench of the voltage element with measurement model
// assumes ms tick shortened to 10 cycles
`timescale 1ns/1ps
module vpe_element_test;
    logic             mclk, rst, regWr, regRd;
    logic [7:0]       regAddr;
    logic [31:0]      regWdata, regRdata, rd;
    logic [1:0]       sel;
    logic [2:0][15:0] level, amps;
    logic [2:0][15:0] phaseFund, phaseRms, phaseAvg, lineFund, lineRms, lineAvg, phaseCurrent;
    logic [2:0]       phasePickupFlag, phaseTripFlag;
    logic             elementPickup, elementTrip;
    logic [3:0]       e;
    int               num_errors, compares, seed, i, k, a, b, c;
    vpe_element #(.TICK_CYCLES(10)) dut (.mclk, .rst, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .phaseFund, .phaseRms, .phaseAvg, .lineFund, .lineRms, .lineAvg,
        .phaseCurrent, .phasePickupFlag, .phaseTripFlag, .elementPickup, .elementTrip);
    vpe_meas_model uMeas (.sel, .level, .amps, .phaseFund, .phaseRms, .phaseAvg, .lineFund,
        .lineRms, .lineAvg, .phaseCurrent);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        regWr <= 1'b1;
        regAddr <= ad;
        regWdata <= {16'h0000, d};
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdr(input logic [7:0] ad);
        regRd <= 1'b1;
        regAddr <= ad;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rd = regRdata;
        @(posedge mclk);
    endtask
    // write then read back with no gap between the strobes
    task automatic wrRd(input logic [7:0] ad, input logic [15:0] d);
        regWr <= 1'b1;
        regAddr <= ad;
        regWdata <= {16'h0000, d};
        @(posedge mclk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rd = regRdata;
        @(posedge mclk);
    endtask
    task automatic setV(input int v0, input int v1, input int v2);
        level <= {16'(v2), 16'(v1), 16'(v0)};
        repeat (5) @(posedge mclk);
    endtask
    // integer reference of the vote; strict compare as the design does
    function automatic logic [3:0] model(int v0, int v1, int v2, int lv, int vote);
        logic [2:0] f;
        f = {v2 > lv, v1 > lv, v0 > lv};
        return {(f[0] + f[1] + f[2]) >= vote, f};
    endfunction
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {rst, regWr, regRd, regAddr, regWdata, sel, level} = '0;
        rst = 1'b1;
        amps = {16'h00C8, 16'h00C8, 16'h00C8};
        seed = 31;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdr(8'h00); chk(rd, 32'h00000040);
        rdr(8'h08); chk(rd, 32'h000003E1);
        rdr(8'h20); chk(rd, 32'h00000000);
        wr(8'h18, 16'h0400);
        wrRd(8'h04, 16'h0400); chk(rd, 32'h00000400);
        for (k = 0; k < 3; k++) begin
            sel <= 2'(k);
            wr(8'h00, 16'h0053 | 16'(k << 2));
            setV(1100, 0, 0); chk({elementPickup, phasePickupFlag}, 4'h9);
            setV(0, 0, 0); chk(elementPickup, 1'b0);
        end
        sel <= 2'h0;
        for (i = 0; i < 12; i++) begin
            k = 1 + ($unsigned($random(seed)) % 3);
            a = 1000 + ($unsigned($random(seed)) % 50);
            b = 1000 + ($unsigned($random(seed)) % 50);
            c = 1000 + ($unsigned($random(seed)) % 50);
            wr(8'h00, 16'h0013 | 16'(k << 6));
            setV(a, b, c);
            e = model(a, b, c, 1024, k);
            chk(elementPickup, e[3]);
            chk(phasePickupFlag, e[3] ? e[2:0] : 3'h0);
            setV(0, 0, 0);
        end
        wr(8'h00, 16'h0053);
        setV(1100, 0, 0);
        setV(1000, 0, 0); chk(elementPickup, 1'b1);
        setV(990, 0, 0); chk(elementPickup, 1'b0);
        wr(8'h08, 16'h041F);
        wr(8'h0C, 16'h0003);
        wr(8'h00, 16'h0051);
        setV(1000, 1100, 1100);
        setV(1050, 1100, 1100); chk(elementPickup, 1'b1);
        repeat (10) @(posedge mclk); chk(elementTrip, 1'b0);
        repeat (25) @(posedge mclk); chk({elementTrip, phaseTripFlag}, 4'h9);
        setV(1060, 1100, 1100); chk({elementPickup, elementTrip}, 2'h0);
        wr(8'h10, 16'h0064);
        wr(8'h14, 16'h0002);
        wr(8'h00, 16'h0151);
        amps <= '0;
        setV(1000, 1100, 1100); chk(elementPickup, 1'b0);
        amps <= {16'h0000, 16'h0000, 16'h00C8};
        repeat (12) @(posedge mclk);
        amps <= '0;
        repeat (2) @(posedge mclk);
        amps <= {16'h0000, 16'h0000, 16'h00C8};
        repeat (12) @(posedge mclk); chk(elementPickup, 1'b0);
        repeat (20) @(posedge mclk); chk(elementPickup, 1'b1);
        amps <= '0;
        wr(8'h00, 16'h0051);
        setV(1000, 1100, 1100); chk(elementPickup, 1'b1);
        wr(8'h00, 16'h0043);
        setV(600, 0, 0); chk(elementPickup, 1'b1);
        wr(8'h00, 16'h0063);
        setV(600, 0, 0); chk(elementPickup, 1'b0);
        wr(8'h00, 16'h0053);
        setV(600, 0, 0); chk(elementPickup, 1'b0);
        wr(8'h00, 16'h0251);
        setV(0, 0, 0); chk(elementPickup, 1'b0);
        wr(8'h00, 16'h0252);
        setV(1100, 0, 0); chk(elementPickup, 1'b0);
        wr(8'h00, 16'h0253);
        setV(1100, 0, 0); chk(elementPickup, 1'b1);
        rdr(8'h1C); chk(rd, 32'h00000141);
        tally_and_finish();
    end
endmodule // vpe_element_test
